// [bench/csm_host_model.sv]
// host side model: two-wire bus master that moves register bytes in and out
`timescale 1ns/1ps
module csm_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h39
) (
   // clocking
   input wire logic clk,
   // bus pins
   input wire logic sda_pull,
   input wire logic sda_val,
   output logic scl,
   output logic sda
);
   logic sda_h;

   // a released line floats up to the pull-up level
   assign sda = sda_h & ~(sda_pull & ~sda_val);

   initial begin
      scl = 1'h1;
      sda_h = 1'h1;
   end

   task automatic hc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // high half-periods of 10 cycles and low half-periods of 12 keep clear of the 8-cycle minimum
   task automatic bit_io(input logic b, output logic r);
      sda_h = b;
      hc(10);
      scl = 1'h1;
      hc(5);
      r = sda;
      hc(5);
      scl = 1'h0;
      hc(2);
   endtask

   task automatic start_c;
      sda_h = 1'h1;
      hc(2);
      scl = 1'h1;
      hc(10);
      sda_h = 1'h0;
      hc(10);
      scl = 1'h0;
      hc(2);
   endtask

   task automatic stop_c;
      sda_h = 1'h0;
      hc(10);
      scl = 1'h1;
      hc(10);
      sda_h = 1'h1;
      hc(10);
   endtask

   task automatic byte_io(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                          output logic a_out);
      logic r;
      q = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(a_in, a_out);
   endtask

   // one whole register byte per write, only what the caller composed
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic k0, k1, k2;
      start_c();
      byte_io({DEV_ADDR, 1'h0}, 1'h1, q, k0);
      byte_io(a, 1'h1, q, k1);
      byte_io(d, 1'h1, q, k2);
      stop_c();
      ok = !(k0 | k1 | k2);
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic k0, k1, k2, k3;
      start_c();
      byte_io({DEV_ADDR, 1'h0}, 1'h1, q, k0);
      byte_io(a, 1'h1, q, k1);
      start_c();
      byte_io({DEV_ADDR, 1'h1}, 1'h1, q, k2);
      byte_io(8'hff, 1'h1, d, k3);
      stop_c();
      ok = !(k0 | k1 | k2);
   endtask
endmodule

// [bench/csm_measure_ctrl_tb.sv]
// self-checking bench for the measure control block through its serial register port
`timescale 1ns/1ps
module csm_measure_ctrl_tb import csm_pkg::*; ;
   localparam logic [6:0] BUS_ADDR = 7'h39; // arbitrary bus address
   localparam int NULL_N = 1500;
   localparam int CONV_N = 1500;
   localparam int STEP_N = 4;
   localparam int LIMIT = 90000;

   logic clk, reset, ce, scl, sda, sda_o, sda_oe, integ_start, integ_active, integ_done;
   logic temp_conv_busy, chan_set_mode, shutter_led_output;
   logic [9:0] temp_sample;
   logic [3:0] zero_request;
   logic [1:0] gain_sel, shutter_led_current_limit, c;
   logic [7:0] v;
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;
   logic [7:0] rst_addr [9] = '{ADDR_GAIN_DRIVE, ADDR_NULLING, ADDR_TEMP_HI, ADDR_TEMP_LO,
      ADDR_TEMP_CTRL, ADDR_INTEG, ADDR_CHAN_SET, ADDR_LED_CTRL, 8'h50};
   logic [7:0] rst_val [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};

   csm_measure_ctrl #(.DEV_ADDR(BUS_ADDR), .STEP_CYCLES(STEP_N), .NULL_CYCLES(NULL_N),
      .CONV_CYCLES(CONV_N)) u_dut (.clk(clk), .reset(reset), .ce(ce), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .temp_sample(temp_sample),
      .zero_request(zero_request), .temp_conv_busy(temp_conv_busy), .gain_sel(gain_sel),
      .chan_set_mode(chan_set_mode), .shutter_led_output(shutter_led_output),
      .shutter_led_current_limit(shutter_led_current_limit), .integ_start(integ_start),
      .integ_active(integ_active), .integ_done(integ_done));

   csm_host_model #(.DEV_ADDR(BUS_ADDR)) u_host (.clk(clk), .sda_pull(sda_oe), .scl(scl),
      .sda_val(sda_o), .sda(sda));

   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      u_host.write_reg(a, d, ok);
      check({9'h000, ok}, 10'h001);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic ok;
      logic [7:0] d;
      u_host.read_reg(a, d, ok);
      check({9'h000, ok}, 10'h001);
      check({2'h0, d}, {2'h0, exp});
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // a hung handshake must still reach the verdict
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         n_fail++;
         end_sim();
      end
   end

   initial begin
      reset = 1'h1;
      ce = 1'h1;
      integ_start = 1'h0;
      temp_sample = 10'h2d6;
      repeat (20) @(negedge clk);
      reset = 1'h0;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 9; i++) rd_chk(rst_addr[i], rst_val[i]);
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         wr(ADDR_GAIN_DRIVE, {~c, 4'h0, c});
         check(gain_sel, c);
         check(shutter_led_current_limit, {8'h00, ~c});
         rd_chk(ADDR_GAIN_DRIVE, {~c, 4'h0, c});
      end
      wr(ADDR_CHAN_SET, 8'h80);
      check(chan_set_mode, 1'h1);
      wr(ADDR_LED_CTRL, 8'h04);
      check(shutter_led_output, 1'h1);
      check(shutter_led_current_limit, 2'h0);
      wr(ADDR_CHAN_SET, 8'h00);
      wr(ADDR_LED_CTRL, 8'h00);
      check({chan_set_mode, shutter_led_output}, 2'h0);
      for (int i = 0; i < 4; i++) begin
         // reserved nulling bits always written as zero
         wr(ADDR_NULLING, 8'h01 << i);
         check(zero_request, 4'h1 << i);
         repeat (NULL_N + 100) @(negedge clk);
         check(zero_request, 4'h0);
         rd_chk(ADDR_NULLING, 8'h80);
         wr(ADDR_NULLING, 8'h00);
         rd_chk(ADDR_NULLING, 8'h00);
      end
      // convert source 0100 together with the start bit
      wr(ADDR_TEMP_CTRL, 8'h24);
      check(temp_conv_busy, 1'h1);
      repeat (CONV_N + 100) @(negedge clk);
      check(temp_conv_busy, 1'h0);
      rd_chk(ADDR_TEMP_CTRL, 8'ha4);
      rd_chk(ADDR_TEMP_HI, 8'hb5);
      rd_chk(ADDR_TEMP_LO, 8'h02);
      wr(ADDR_TEMP_CTRL, 8'h00);
      rd_chk(ADDR_TEMP_CTRL, 8'h00);
      // an abort in mid-conversion must leave the old result alone
      temp_sample = 10'h129;
      wr(ADDR_TEMP_CTRL, 8'h20);
      check(temp_conv_busy, 1'h0);
      wr(ADDR_TEMP_CTRL, 8'h24);
      wr(ADDR_TEMP_CTRL, 8'h00);
      check(temp_conv_busy, 1'h0);
      repeat (CONV_N + 100) @(negedge clk);
      rd_chk(ADDR_TEMP_CTRL, 8'h00);
      rd_chk(ADDR_TEMP_HI, 8'hb5);
      for (int k = 0; k < 2; k++) begin
         v = (k == 1) ? 8'hfd : 8'hff;
         if (k == 1) wr(ADDR_INTEG, v);
         integ_start = 1'h1;
         @(negedge clk);
         integ_start = 1'h0;
         check(integ_active, 1'h1);
         n = 0;
         while (integ_done !== 1'h1 && n < 5000) begin
            @(negedge clk);
            n++;
         end
         check(10'(n), 10'((256 - v) * STEP_N));
         @(negedge clk);
         check({integ_done, integ_active}, 2'h0);
      end
      end_sim();
   end
endmodule

// [rtl/csm_measure_ctrl.sv]
// measure control registers: offset nulling, temperature conversion, gain, shutter drive, timing
//
// Functional notes
// - nulling done flag sets; written zero clears it
// - writing request bit starts that channel's nulling
// - request bits clear when done flag sets
// - temperature high register holds result bits 9:2
// - temperature low register holds result bits 1:0
// - conversion complete flag sets; written zero clears
// - start bit with convert source 0100 begins conversion; zero returns idle
// - channel set bit picks mode 0 or 1
// - drive current field limits shutter output current
// - gain field applies one gain to all channels
// - integration lasts 256 minus value steps of 2.8 ms
// - shutter on bit switches drive at chosen limit
`timescale 1ns/1ps
module csm_measure_ctrl import csm_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = 7'h39, // arbitrary bus address
   parameter int STEP_CYCLES = INTEG_STEP_CYCLES,
   parameter int NULL_CYCLES = 64,
   parameter int CONV_CYCLES = 128
) (
   // clocking
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // serial register pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // analog front end
   input wire logic [9:0] temp_sample,
   output logic [3:0] zero_request,
   output logic temp_conv_busy,
   output logic [1:0] gain_sel,
   output logic chan_set_mode,
   // shutter drive
   output logic shutter_led_output,
   output logic [1:0] shutter_led_current_limit,
   // integration timing
   input wire logic integ_start,
   output logic integ_active,
   output logic integ_done
);
   localparam int NW = $clog2(NULL_CYCLES + 1);
   localparam int CW = $clog2(CONV_CYCLES + 1);
   localparam int SW = $clog2(STEP_CYCLES + 1);

   logic wr_en;
   logic [7:0] wr_addr, wr_data, ptr, rd_data_r;
   logic [7:0] gain_drive_r, integ_len_r;
   logic chan_set_r, led_on_r;
   logic [3:0] null_req_r;
   logic null_done_r;
   logic [NW-1:0] null_cnt_r;
   logic null_fin;
   logic temp_flag_r, temp_start_r, conv_busy_r;
   logic [3:0] temp_src_r;
   logic [CW-1:0] conv_cnt_r;
   logic conv_fin;
   logic [TEMP_W-1:0] temp_result_word;
   logic [SW-1:0] pre_cnt_r;
   logic [8:0] steps_r;
   logic integ_active_r, integ_done_r;
   logic wr_gain, wr_null, wr_tctrl, wr_integ, wr_chan, wr_led;

   csm_ser_slave #(.DEV_ADDR(DEV_ADDR)) u_ser (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .ptr(ptr),
      .rd_data(rd_data_r)
   );

   assign wr_gain = wr_hit(wr_en, wr_addr, ADDR_GAIN_DRIVE);
   assign wr_null = wr_hit(wr_en, wr_addr, ADDR_NULLING);
   assign wr_tctrl = wr_hit(wr_en, wr_addr, ADDR_TEMP_CTRL);
   assign wr_integ = wr_hit(wr_en, wr_addr, ADDR_INTEG);
   assign wr_chan = wr_hit(wr_en, wr_addr, ADDR_CHAN_SET);
   assign wr_led = wr_hit(wr_en, wr_addr, ADDR_LED_CTRL);

   // plain read/write settings; gain/drive stores all 8 bits, its reserved bits read back as zero
   always_ff @(posedge clk) begin
      if (reset) begin
         gain_drive_r <= RST_GAIN_DRIVE;
         integ_len_r <= RST_INTEG;
         chan_set_r <= 1'b0;
         led_on_r <= 1'b0;
      end else if (ce) begin
         if (wr_gain) begin
            gain_drive_r <= wr_data;
         end
         if (wr_integ) begin
            integ_len_r <= wr_data;
         end
         if (wr_chan) begin
            chan_set_r <= wr_data[CHAN_SET_BIT];
         end
         if (wr_led) begin
            led_on_r <= wr_data[LED_ON_BIT];
         end
      end
   end

   assign chan_set_mode = chan_set_r;
   assign gain_sel = gain_drive_r[GAIN_MSB:0];
   assign shutter_led_current_limit = gain_drive_r[LED_CUR_MSB:LED_CUR_LSB];
   assign shutter_led_output = led_on_r;

   // offset nulling: one shared run covers all requested channels
   assign null_fin = (null_req_r != RST_NULL_REQ) && (null_cnt_r == NW'(NULL_CYCLES - 1));
   always_ff @(posedge clk) begin
      if (reset) begin
         null_req_r <= RST_NULL_REQ;
         null_done_r <= 1'b0;
         null_cnt_r <= '0;
      end else if (ce) begin
         if (null_fin) begin
            null_req_r <= RST_NULL_REQ;
            null_cnt_r <= '0;
         end else begin
            if (wr_null) begin
               null_req_r <= wr_data[NULL_REQ_MSB:0];
            end
            if (null_req_r != RST_NULL_REQ) begin
               null_cnt_r <= null_cnt_r + NW'(1);
            end
         end
         // completion wins over a clearing write
         if (null_fin) begin
            null_done_r <= 1'b1;
         end else if (wr_null && !wr_data[NULL_DONE_BIT]) begin
            null_done_r <= 1'b0;
         end
      end
   end
   assign zero_request = null_req_r;

   // temperature converter; a result is taken from the front end at the end of the run
   assign conv_fin = conv_busy_r && (conv_cnt_r == CW'(CONV_CYCLES - 1));
   always_ff @(posedge clk) begin
      if (reset) begin
         temp_start_r <= 1'b0;
         temp_src_r <= RST_TEMP_SRC;
         conv_busy_r <= 1'b0;
         conv_cnt_r <= '0;
      end else if (ce) begin
         if (wr_tctrl) begin
            temp_start_r <= wr_data[TEMP_START_BIT];
            temp_src_r <= wr_data[TEMP_SRC_MSB:0];
            // start with convert source, zero aborts to idle
            conv_busy_r <= wr_data[TEMP_START_BIT] && (wr_data[TEMP_SRC_MSB:0] == SRC_CONVERT);
            conv_cnt_r <= '0;
         end else if (conv_fin) begin
            conv_busy_r <= 1'b0;
            conv_cnt_r <= '0;
         end else if (conv_busy_r) begin
            conv_cnt_r <= conv_cnt_r + CW'(1);
         end
      end
   end
   assign temp_conv_busy = conv_busy_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         temp_flag_r <= 1'b0;
         temp_result_word <= RST_TEMP_RESULT;
      end else if (ce) begin
         // a write landing in the finishing cycle still keeps the finished result
         if (conv_fin) begin
            temp_result_word <= temp_sample;
         end
         if (conv_fin) begin
            temp_flag_r <= 1'b1;
         end else if (wr_tctrl && !wr_data[TEMP_FLAG_BIT]) begin
            temp_flag_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pre_cnt_r <= '0;
         steps_r <= '0;
         integ_active_r <= 1'b0;
         integ_done_r <= 1'b0;
      end else if (ce) begin
         integ_done_r <= 1'b0;
         if (integ_start && !integ_active_r) begin
            steps_r <= INTEG_FULL - {1'b0, integ_len_r};
            pre_cnt_r <= '0;
            integ_active_r <= 1'b1;
         end else if (integ_active_r) begin
            if (pre_cnt_r == SW'(STEP_CYCLES - 1)) begin
               pre_cnt_r <= '0;
               steps_r <= steps_r - 9'h001;
               if (steps_r == 9'h001) begin
                  integ_active_r <= 1'b0;
                  integ_done_r <= 1'b1;
               end
            end else begin
               pre_cnt_r <= pre_cnt_r + SW'(1);
            end
         end
      end
   end
   assign integ_active = integ_active_r;
   assign integ_done = integ_done_r;

   // read mux registered; the port samples it well after the pointer settles
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data_r <= RD_ZERO;
      end else if (ce) begin
         case (ptr)
            ADDR_GAIN_DRIVE: rd_data_r <= {gain_drive_r[LED_CUR_MSB:LED_CUR_LSB], 4'h0,
                                           gain_drive_r[GAIN_MSB:0]};
            ADDR_NULLING: rd_data_r <= {null_done_r, 3'h0, null_req_r};
            ADDR_TEMP_HI: rd_data_r <= temp_result_word[TEMP_W-1:TEMP_HI_LSB];
            ADDR_TEMP_LO: rd_data_r <= {6'h00, temp_result_word[TEMP_HI_LSB-1:0]};
            ADDR_TEMP_CTRL: rd_data_r <= {temp_flag_r, 1'b0, temp_start_r, 1'b0, temp_src_r};
            ADDR_INTEG: rd_data_r <= integ_len_r;
            ADDR_CHAN_SET: rd_data_r <= {chan_set_r, 7'h00};
            ADDR_LED_CTRL: rd_data_r <= {5'h00, led_on_r, 2'h0};
            default: rd_data_r <= RD_ZERO;
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_null_end;
      ce && null_fin;
   endsequence
   property p_null_done;
      s_null_end |=> null_done_r;
   endproperty
   a_null_done: assert property (p_null_done) else $error("nulling done flag not set");
   property p_null_clear;
      s_null_end |=> (zero_request == 4'h0);
   endproperty
   a_null_clear: assert property (p_null_clear) else $error("requests not cleared");
   property p_null_start;
      ce && wr_null && !null_fin && (wr_data[NULL_REQ_MSB:0] != 4'h0)
         |=> zero_request == $past(wr_data[NULL_REQ_MSB:0]);
   endproperty
   a_null_start: assert property (p_null_start) else $error("nulling not started");
   property p_temp_split;
      ce && conv_fin
         |=> (temp_result_word[TEMP_W-1:TEMP_HI_LSB] == $past(temp_sample[TEMP_W-1:TEMP_HI_LSB]))
         && (temp_result_word[TEMP_HI_LSB-1:0] == $past(temp_sample[TEMP_HI_LSB-1:0]))
         && temp_flag_r;
   endproperty
   a_temp_split: assert property (p_temp_split) else $error("result or flag wrong");
   property p_temp_read;
      ce && ptr == ADDR_TEMP_HI && !conv_fin
         |=> rd_data_r == temp_result_word[TEMP_W-1:TEMP_HI_LSB];
   endproperty
   a_temp_read: assert property (p_temp_read) else $error("high result read wrong");
   property p_temp_lo;
      ce && ptr == ADDR_TEMP_LO && !conv_fin
         |=> rd_data_r == {6'h00, temp_result_word[TEMP_HI_LSB-1:0]};
   endproperty
   a_temp_lo: assert property (p_temp_lo) else $error("low result read wrong");
   property p_temp_idle;
      ce && wr_tctrl && !wr_data[TEMP_START_BIT] |=> !temp_conv_busy;
   endproperty
   a_temp_idle: assert property (p_temp_idle) else $error("converter not idle");
   property p_chan;
      ce && wr_chan |=> chan_set_mode == $past(wr_data[CHAN_SET_BIT]);
   endproperty
   a_chan: assert property (p_chan) else $error("channel set not applied");
   property p_gain;
      ce && wr_gain |=> (gain_sel == $past(wr_data[GAIN_MSB:0]))
         && (shutter_led_current_limit == $past(wr_data[LED_CUR_MSB:LED_CUR_LSB]));
   endproperty
   a_gain: assert property (p_gain) else $error("gain or limit not applied");
   property p_led;
      ce && wr_led |=> shutter_led_output == $past(wr_data[LED_ON_BIT]);
   endproperty
   a_led: assert property (p_led) else $error("shutter switch wrong");
   property p_integ;
      ce && integ_start && !integ_active |=> integ_active
         && (steps_r == INTEG_FULL - {1'b0, $past(integ_len_r)});
   endproperty
   a_integ: assert property (p_integ) else $error("integration steps wrong");
   sequence s_last_step;
      ce && integ_active && (pre_cnt_r == SW'(STEP_CYCLES - 1)) && (steps_r == 9'h001);
   endsequence
   property p_integ_end;
      s_last_step |=> integ_done && !integ_active;
   endproperty
   a_integ_end: assert property (p_integ_end) else $error("integration did not end");
endmodule

// [rtl/csm_pkg.sv]
// shared register map, field positions, timing and state types for the measure control block
package csm_pkg;
   // register addresses on the serial register port
   localparam logic [7:0] ADDR_GAIN_DRIVE = 8'hb9;
   localparam logic [7:0] ADDR_NULLING = 8'hba;
   localparam logic [7:0] ADDR_TEMP_HI = 8'hd1;
   localparam logic [7:0] ADDR_TEMP_LO = 8'hd2;
   localparam logic [7:0] ADDR_TEMP_CTRL = 8'hd3;
   localparam logic [7:0] ADDR_INTEG = 8'hd9;
   localparam logic [7:0] ADDR_CHAN_SET = 8'hdb;
   localparam logic [7:0] ADDR_LED_CTRL = 8'hea;
   // reset values
   localparam logic [7:0] RST_GAIN_DRIVE = 8'h00;
   localparam logic [3:0] RST_NULL_REQ = 4'h0;
   localparam logic [3:0] RST_TEMP_SRC = 4'h0;
   localparam logic [7:0] RST_INTEG = 8'hff;
   localparam logic [9:0] RST_TEMP_RESULT = 10'h000;
   localparam logic [7:0] RD_ZERO = 8'h00;
   // field positions
   localparam int NULL_DONE_BIT = 7;
   localparam int NULL_REQ_MSB = 3;
   localparam int TEMP_FLAG_BIT = 7;
   localparam int TEMP_START_BIT = 5;
   localparam int TEMP_SRC_MSB = 3;
   localparam int CHAN_SET_BIT = 7;
   localparam int LED_CUR_MSB = 7;
   localparam int LED_CUR_LSB = 6;
   localparam int GAIN_MSB = 1;
   localparam int LED_ON_BIT = 2;
   localparam int TEMP_W = 10;
   localparam int TEMP_HI_LSB = 2;
   // conversion source codes
   localparam logic [3:0] SRC_CONVERT = 4'h4;
   localparam logic [3:0] SRC_IDLE = 4'h0;
   // integration step: 256 minus register value, each step 2.8 ms
   localparam logic [8:0] INTEG_FULL = 9'h100;
   localparam int CLK_MHZ = 200;
   localparam int INTEG_STEP_US = 2800;
   localparam int INTEG_STEP_CYCLES = INTEG_STEP_US * CLK_MHZ;
   // serial port state
   typedef enum logic [2:0] {
      CSM_IDLE, CSM_ADDR, CSM_ACK_ADDR, CSM_WBYTE, CSM_ACK_W, CSM_RBYTE, CSM_RACK
   } csm_ser_st_t;
   // write hit decode shared by every writable register
   function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] t);
      return en && (a == t);
   endfunction
endpackage

// [rtl/csm_ser_slave.sv]
// two-wire serial register port: address, register pointer, auto-increment reads and writes
`timescale 1ns/1ps
module csm_ser_slave import csm_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = 7'h39
) (
   // clocking
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // register side
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   output logic [7:0] ptr,
   input wire logic [7:0] rd_data
);
   logic [1:0] scl_sy_r, sda_sy_r;
   logic scl_d_r, sda_d_r;
   csm_ser_st_t st_r;
   logic [7:0] sh_r;
   logic [3:0] cnt_r;
   logic rw_r, first_r;
   logic scl_rise, scl_fall, start_c, stop_c;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // two-stage sync; only the second stage feeds the edge and start/stop logic
   always_ff @(posedge clk) begin
      if (reset) begin
         scl_sy_r <= 2'h3;
         sda_sy_r <= 2'h3;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else if (ce) begin
         scl_sy_r <= {scl_sy_r[0], scl_i};
         sda_sy_r <= {sda_sy_r[0], sda_i};
         scl_d_r <= scl_sy_r[1];
         sda_d_r <= sda_sy_r[1];
      end
   end

   assign scl_rise = scl_sy_r[1] && !scl_d_r;
   assign scl_fall = !scl_sy_r[1] && scl_d_r;
   assign start_c = scl_sy_r[1] && scl_d_r && !sda_sy_r[1] && sda_d_r;
   assign stop_c = scl_sy_r[1] && scl_d_r && sda_sy_r[1] && !sda_d_r;
   assign sda_o = 1'b0;

   always_ff @(posedge clk) begin
      if (reset) begin
         st_r <= CSM_IDLE;
         sh_r <= 8'h00;
         cnt_r <= 4'h0;
         rw_r <= 1'b0;
         first_r <= 1'b0;
         sda_oe <= 1'b0;
         wr_en <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
         ptr <= 8'h00;
      end else if (ce) begin
         wr_en <= 1'b0;
         if (start_c) begin
            st_r <= CSM_ADDR;
            cnt_r <= 4'h0;
            first_r <= 1'b1;
            sda_oe <= 1'b0;
         end else if (stop_c) begin
            st_r <= CSM_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (st_r)
               CSM_ADDR, CSM_WBYTE: begin
                  if (scl_rise) begin
                     sh_r <= {sh_r[6:0], sda_sy_r[1]};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall && cnt_r == BYTE_BITS) begin
                     cnt_r <= 4'h0;
                     if (st_r == CSM_ADDR) begin
                        // a foreign address leaves the bus alone until the next start
                        if (sh_r[7:1] == DEV_ADDR) begin
                           rw_r <= sh_r[0];
                           sda_oe <= 1'b1;
                           st_r <= CSM_ACK_ADDR;
                        end else begin
                           st_r <= CSM_IDLE;
                        end
                     end else begin
                        if (first_r) begin
                           ptr <= sh_r;
                           first_r <= 1'b0;
                        end else begin
                           wr_en <= 1'b1;
                           wr_addr <= ptr;
                           wr_data <= sh_r;
                           ptr <= ptr + 8'h01;
                        end
                        sda_oe <= 1'b1;
                        st_r <= CSM_ACK_W;
                     end
                  end
               end
               CSM_ACK_ADDR: begin
                  if (scl_fall) begin
                     if (rw_r) begin
                        sh_r <= rd_data;
                        sda_oe <= !rd_data[7];
                        st_r <= CSM_RBYTE;
                     end else begin
                        sda_oe <= 1'b0;
                        st_r <= CSM_WBYTE;
                     end
                  end
               end
               CSM_ACK_W: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     st_r <= CSM_WBYTE;
                  end
               end
               CSM_RBYTE: begin
                  if (scl_rise) begin
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall) begin
                     if (cnt_r == BYTE_BITS) begin
                        sda_oe <= 1'b0;
                        cnt_r <= 4'h0;
                        st_r <= CSM_RACK;
                     end else begin
                        sh_r <= {sh_r[6:0], 1'b0};
                        sda_oe <= !sh_r[6];
                     end
                  end
               end
               CSM_RACK: begin
                  if (scl_rise) begin
                     if (sda_sy_r[1]) begin
                        st_r <= CSM_IDLE;
                     end else begin
                        ptr <= ptr + 8'h01;
                     end
                  end else if (scl_fall) begin
                     sh_r <= rd_data;
                     sda_oe <= !rd_data[7];
                     st_r <= CSM_RBYTE;
                  end
               end
               default: st_r <= CSM_IDLE;
            endcase
         end
      end
   end
endmodule
